// [rtl/bstp_cell.sv]
`timescale 1ns/1ps
module bstp_cell
#(
   parameter bit MC = 1'b0
)
(
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic capture,
   input  wire logic shift,
   input  wire logic update,
   input  wire logic si,
   output logic      so,
   input  wire logic obs_in,
   input  wire logic obs_out,
   input  wire logic obs_oe,
   output logic      upd_out,
   output logic      upd_oe
);
   import bstp_pkg::*;

   logic [2:0] cap;
   logic [2:0] next_cap;
   logic       next_upd_out;
   logic       next_upd_oe;

   // Three capture stages sample, shift or hold; update stages follow them.
   always_comb
   begin
      next_cap     = cap;
      next_upd_out = upd_out;
      next_upd_oe  = upd_oe;
      if (capture)
         next_cap = {obs_oe, obs_out, obs_in};
      else if (shift)
         next_cap = {si, cap[2:1]};
      if (update)
      begin
         next_upd_out = cap[1];
         // A macrocell cell has a single update stage.
         next_upd_oe  = MC ? 1'b0 : cap[2];
      end
   end

   // Registers the cell state.
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cap     <= CELL_RST;
         upd_out <= 1'b0;
         upd_oe  <= 1'b0;
      end
      else
      begin
         cap     <= next_cap;
         upd_out <= next_upd_out;
         upd_oe  <= next_upd_oe;
      end
   end

   assign so = cap[0];

   cell_capture_a: assert property (
      @(posedge clk) disable iff (!rstn)
      capture |=> cap == $past({obs_oe, obs_out, obs_in}))
      else $error("Scan cell did not capture its three signals.");

endmodule

// [rtl/bstp_pkg.sv]
package bstp_pkg;

   // Default sizes of the scan chain segments.
   localparam int N_IN_DEF    = 4;
   localparam int N_IO_DEF    = 68;
   localparam int N_MC_DEF    = 64;

   // Instruction register width and opcodes.
   localparam int IR_LEN      = 4;
   localparam logic [IR_LEN-1:0] OP_EXTEST = 4'h0;
   localparam logic [IR_LEN-1:0] OP_SAMPLE = 4'h1;
   localparam logic [IR_LEN-1:0] OP_IDCODE = 4'h2;
   localparam logic [IR_LEN-1:0] OP_HIGHZ  = 4'h3;
   localparam logic [IR_LEN-1:0] OP_BYPASS = 4'hF;

   // Value loaded into the instruction shifter in the capture state.
   localparam logic [IR_LEN-1:0] IR_CAPT   = 4'h1;
   // Instruction in force after reset and in the reset state.
   localparam logic [IR_LEN-1:0] IR_RST    = OP_IDCODE;

   // Width of the identification register.
   localparam int ID_LEN      = 32;
   // Index of each test port pin inside the four-bit pin groups.
   localparam int TP_TCK      = 0;
   localparam int TP_TMS      = 1;
   localparam int TP_TDI      = 2;
   localparam int TP_TDO      = 3;
   // Reset value of the scan cell stages.
   localparam logic [2:0] CELL_RST = 3'h0;

   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SHF_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SHF_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } bstp_state_t;

   typedef enum logic [2:0] {
      INS_EXTEST, INS_SAMPLE, INS_IDCODE, INS_HIGHZ, INS_BYPASS
   } bstp_ins_t;

   // Maps an opcode to one of the five instructions; others act as bypass.
   function automatic bstp_ins_t bstp_decode(input logic [IR_LEN-1:0] op);
      case (op)
         OP_EXTEST: return INS_EXTEST;
         OP_SAMPLE: return INS_SAMPLE;
         OP_IDCODE: return INS_IDCODE;
         OP_HIGHZ:  return INS_HIGHZ;
         default:   return INS_BYPASS;
      endcase
   endfunction

endpackage

// [rtl/bstp_top.sv]
// Functional notes
// - Every dedicated input and I/O pin owns a scan cell.
// - Cell count follows 68 I/O, four input pins and 64 macrocells, set by parameter.
// - No test reset pin; power-up reset forces the controller to reset.
// - Instructions: sample/preload, extest, bypass, idcode, highz.
// - With the test port disabled its four pins are plain I/O.
// - Programming enters only through the four serial test port pins.
// - Each cell holds three capture stages and up to two update stages.
// - Pin cells and macrocell cells are two distinct kinds.
// - Cells chain through capture stages from TDI to TDO.
// - Capture stages sample, shift, and load the update stages.
// - The port state machine makes all capture, shift, update strobes.
// - The four test port pins have no ordinary pin scan cell.
// - Optional pull-ups on TMS and TDI chosen at design time.
`timescale 1ns/1ps
module bstp_top
#(
   parameter int          N_IN       = bstp_pkg::N_IN_DEF,
   parameter int          N_IO       = bstp_pkg::N_IO_DEF,
   parameter int          N_MC       = bstp_pkg::N_MC_DEF,
   parameter bit          PULLUP_TMS = 1'b1,
   parameter bit          PULLUP_TDI = 1'b1,
   // Identification value is arbitrary; bit zero must stay one.
   parameter logic [31:0] ID_VALUE   = 32'h0000_0001
)
(
   input  wire logic                 core_clk,
   input  wire logic                 rstn,
   input  wire logic                 test_port_en,
   input  wire logic [3:0]           tp_pin_in,
   output logic [3:0]                tp_pin_out,
   output logic [3:0]                tp_pin_oe,
   input  wire logic [3:0]           tp_out,
   input  wire logic [3:0]           tp_oe,
   output logic [3:0]                tp_gpio_in,
   output logic                      tms_pull_en,
   output logic                      tdi_pull_en,
   input  wire logic [N_IN+N_IO-1:0] pad_in,
   input  wire logic [N_IO-1:0]      core_out,
   input  wire logic [N_IO-1:0]      core_oe,
   output logic [N_IO-1:0]           pad_out,
   output logic [N_IO-1:0]           pad_oe,
   output logic [N_IN+N_IO-1:0]      core_in,
   input  wire logic [N_MC-1:0]      mc_fb,
   input  wire logic [N_MC-1:0]      mc_out,
   input  wire logic [N_MC-1:0]      mc_oe,
   output logic [N_MC-1:0]           mc_fb_core
);
   import bstp_pkg::*;

   localparam int NP = N_IN + N_IO;
   localparam int NC = NP + N_MC;
   localparam int SW = 4 + NP;

   logic [SW-1:0]     sync1;
   logic [SW-1:0]     sync2;
   logic [SW-1:0]     sync3;
   logic [SW-1:0]     pin_q;
   logic [SW-1:0]     next_pin_q;
   logic              tck_rise;
   logic              tck_fall;
   logic              tms;
   logic              tdi;
   bstp_state_t       state;
   bstp_state_t       next_state;
   logic [IR_LEN-1:0] ir;
   logic [IR_LEN-1:0] next_ir;
   logic [IR_LEN-1:0] ir_sr;
   logic [IR_LEN-1:0] next_ir_sr;
   logic              bypass_q;
   logic              next_bypass_q;
   logic [ID_LEN-1:0] id_sr;
   logic [ID_LEN-1:0] next_id_sr;
   logic              tdo_q;
   logic              next_tdo_q;
   logic              tdo_oe_q;
   logic              next_tdo_oe_q;
   bstp_ins_t         ins;
   logic              bsr_sel;
   logic              cap_dr;
   logic              shf_dr;
   logic              upd_dr;
   logic [NC:0]       chain;
   logic [NC-1:0]     upd_out;
   logic [NC-1:0]     upd_oe;
   logic [NP-1:0]     pad_q;
   logic [N_IO-1:0]   next_pad_out;
   logic [N_IO-1:0]   next_pad_oe;
   logic [NP-1:0]     next_core_in;
   logic [N_MC-1:0]   next_mc_fb_core;
   logic [3:0]        next_tp_pin_out;
   logic [3:0]        next_tp_pin_oe;
   logic [3:0]        next_tp_gpio_in;
   logic              next_tms_pull_en;
   logic              next_tdi_pull_en;

   // Next state of the sixteen-state test port sequence.
   function automatic bstp_state_t tap_next(input bstp_state_t s,
                                            input logic t);
      case (s)
         TLR:     return t ? TLR    : RTI;
         RTI:     return t ? SEL_DR : RTI;
         SEL_DR:  return t ? SEL_IR : CAP_DR;
         CAP_DR:  return t ? EX1_DR : SHF_DR;
         SHF_DR:  return t ? EX1_DR : SHF_DR;
         EX1_DR:  return t ? UPD_DR : PAU_DR;
         PAU_DR:  return t ? EX2_DR : PAU_DR;
         EX2_DR:  return t ? UPD_DR : SHF_DR;
         UPD_DR:  return t ? SEL_DR : RTI;
         SEL_IR:  return t ? TLR    : CAP_IR;
         CAP_IR:  return t ? EX1_IR : SHF_IR;
         SHF_IR:  return t ? EX1_IR : SHF_IR;
         EX1_IR:  return t ? UPD_IR : PAU_IR;
         PAU_IR:  return t ? EX2_IR : PAU_IR;
         EX2_IR:  return t ? UPD_IR : SHF_IR;
         UPD_IR:  return t ? SEL_DR : RTI;
         default: return TLR;
      endcase
   endfunction

   // Three-flop synchronisers; a level counts when stages two and three agree.
   always_comb
   begin
      next_pin_q = (sync2 & sync3) | (pin_q & (sync2 ^ sync3));
   end

   // Registers the synchroniser chain.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
         pin_q <= '0;
      end
      else
      begin
         sync1 <= {pad_in, tp_pin_in};
         sync2 <= sync1;
         sync3 <= sync2;
         pin_q <= next_pin_q;
      end
   end

   // Test clock edges are found from the agreed level of the sampled pin.
   assign tck_rise = !pin_q[TP_TCK] && next_pin_q[TP_TCK];
   assign tck_fall = pin_q[TP_TCK] && !next_pin_q[TP_TCK];
   assign tms      = pin_q[TP_TMS];
   assign tdi      = pin_q[TP_TDI];
   assign pad_q    = pin_q[SW-1:4];
   assign ins      = bstp_decode(ir);
   assign bsr_sel  = (ins == INS_EXTEST) || (ins == INS_SAMPLE);

   // Cell strobes come only from the controller state, the instruction and test clock edges.
   assign cap_dr = test_port_en && tck_rise && state == CAP_DR
                   && bsr_sel;
   assign shf_dr = test_port_en && tck_rise && state == SHF_DR && bsr_sel;
   assign upd_dr = test_port_en && tck_fall && state == UPD_DR && bsr_sel;

   // Controller, instruction, bypass, identification and TDO next values.
   always_comb
   begin
      next_state    = state;
      next_ir       = ir;
      next_ir_sr    = ir_sr;
      next_bypass_q = bypass_q;
      next_id_sr    = id_sr;
      next_tdo_q    = tdo_q;
      next_tdo_oe_q = tdo_oe_q;
      if (!test_port_en)
      begin
         next_state    = TLR;
         next_ir       = IR_RST;
         next_tdo_oe_q = 1'b0;
      end
      else
      begin
         if (tck_rise)
         begin
            next_state = tap_next(state, tms);
            case (state)
               CAP_IR:  next_ir_sr = IR_CAPT;
               SHF_IR:  next_ir_sr = {tdi, ir_sr[IR_LEN-1:1]};
               CAP_DR:
               begin
                  next_bypass_q = 1'b0;
                  next_id_sr    = ID_VALUE;
               end
               SHF_DR:
               begin
                  next_bypass_q = tdi;
                  next_id_sr    = {tdi, id_sr[ID_LEN-1:1]};
               end
               default: ;
            endcase
         end
         if (tck_fall)
         begin
            case (state)
               TLR:     next_ir = IR_RST;
               UPD_IR:  next_ir = ir_sr;
               default: ;
            endcase
            next_tdo_oe_q = (state == SHF_DR) || (state == SHF_IR);
            if (state == SHF_IR)
               next_tdo_q = ir_sr[0];
            else if (ins == INS_IDCODE)
               next_tdo_q = id_sr[0];
            else if (bsr_sel)
               next_tdo_q = chain[0];
            else
               next_tdo_q = bypass_q;
         end
      end
   end

   // Power-up reset puts the controller in its reset state.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state    <= TLR;
         ir       <= IR_RST;
         ir_sr    <= IR_CAPT;
         bypass_q <= 1'b0;
         id_sr    <= '0;
         tdo_q    <= 1'b0;
         tdo_oe_q <= 1'b0;
      end
      else
      begin
         state    <= next_state;
         ir       <= next_ir;
         ir_sr    <= next_ir_sr;
         bypass_q <= next_bypass_q;
         id_sr    <= next_id_sr;
         tdo_q    <= next_tdo_q;
         tdo_oe_q <= next_tdo_oe_q;
      end
   end

   // Pin cells come first in the chain, macrocell cells nearest to TDI.
   assign chain[NC] = tdi;
   genvar gi;
   generate
      for (gi = 0; gi < NC; gi++)
      begin : g_cell
         logic o_val;
         logic o_en;
         logic i_val;
         if (gi < N_IN)
         begin : g_in
            assign i_val = pad_q[gi];
            assign o_val = 1'b0;
            assign o_en  = 1'b0;
         end
         else if (gi < NP)
         begin : g_io
            assign i_val = pad_q[gi];
            assign o_val = core_out[gi-N_IN];
            assign o_en  = core_oe[gi-N_IN];
         end
         else
         begin : g_mc
            assign i_val = mc_fb[gi-NP];
            assign o_val = mc_out[gi-NP];
            assign o_en  = mc_oe[gi-NP];
         end
         bstp_cell #(.MC(gi >= NP)) u_cell (
            .clk     (core_clk),
            .rstn    (rstn),
            .capture (cap_dr),
            .shift   (shf_dr),
            .update  (upd_dr),
            .si      (chain[gi+1]),
            .so      (chain[gi]),
            .obs_in  (i_val),
            .obs_out (o_val),
            .obs_oe  (o_en),
            .upd_out (upd_out[gi]),
            .upd_oe  (upd_oe[gi])
         );
      end
   endgenerate

   // Pin, core and test port outputs; test port pins bypass the cells.
   always_comb
   begin
      next_core_in    = pad_q;
      next_pad_out    = core_out;
      next_pad_oe     = core_oe;
      next_mc_fb_core = mc_fb;
      next_tms_pull_en = test_port_en && PULLUP_TMS;
      next_tdi_pull_en = test_port_en && PULLUP_TDI;
      if (ins == INS_EXTEST)
      begin
         next_core_in    = upd_out[NP-1:0];
         next_pad_out    = upd_out[NP-1:N_IN];
         next_pad_oe     = upd_oe[NP-1:N_IN];
         next_mc_fb_core = upd_out[NC-1:NP];
      end
      else if (ins == INS_HIGHZ)
         next_pad_oe = '0;
      if (test_port_en)
      begin
         next_tp_pin_out = {tdo_q, 3'h0};
         next_tp_pin_oe  = {tdo_oe_q, 3'h0};
         next_tp_gpio_in = 4'h0;
      end
      else
      begin
         next_tp_pin_out = tp_out;
         next_tp_pin_oe  = tp_oe;
         next_tp_gpio_in = pin_q[3:0];
      end
   end

   // Registers every top-level output.
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         core_in     <= '0;
         pad_out     <= '0;
         pad_oe      <= '0;
         mc_fb_core  <= '0;
         tp_pin_out  <= 4'h0;
         tp_pin_oe   <= 4'h0;
         tp_gpio_in  <= 4'h0;
         tms_pull_en <= 1'b0;
         tdi_pull_en <= 1'b0;
      end
      else
      begin
         core_in     <= next_core_in;
         pad_out     <= next_pad_out;
         pad_oe      <= next_pad_oe;
         mc_fb_core  <= next_mc_fb_core;
         tp_pin_out  <= next_tp_pin_out;
         tp_pin_oe   <= next_tp_pin_oe;
         tp_gpio_in  <= next_tp_gpio_in;
         tms_pull_en <= next_tms_pull_en;
         tdi_pull_en <= next_tdi_pull_en;
      end
   end

   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!rstn);

   port_off_tlr_a: assert property (
      !test_port_en |=> state == TLR && ir == IR_RST)
      else $error("Disabled test port left the controller running.");

   gpio_pass_a: assert property (
      !test_port_en |=> tp_pin_oe == $past(tp_oe)
                        && tp_gpio_in == $past(pin_q[3:0]))
      else $error("Disabled test port pins are not plain I/O.");

   state_on_rise_a: assert property (
      state != $past(state) && $past(test_port_en) |-> $past(tck_rise))
      else $error("Controller moved without a test clock rise.");

   ir_capture_a: assert property (
      tck_rise && test_port_en && state == CAP_IR |=> ir_sr == IR_CAPT)
      else $error("Instruction shifter missed its capture value.");

   highz_float_a: assert property (
      ins == INS_HIGHZ |=> pad_oe == '0)
      else $error("High-impedance instruction left a pad driven.");

   bypass_bit_a: assert property (
      tck_rise && test_port_en && state == SHF_DR |=> bypass_q == $past(tdi))
      else $error("Bypass stage did not take TDI.");

   tdo_oe_fall_a: assert property (
      $rose(tp_pin_oe[TP_TDO]) && $past(test_port_en, 2)
         |-> $past(tck_fall, 2))
      else $error("TDO drive began away from a test clock fall.");

   strobe_src_a: assert property (
      cap_dr || shf_dr || upd_dr
         |-> test_port_en && bsr_sel && (tck_rise || tck_fall))
      else $error("Cell strobe fired outside the controller.");

   extest_drive_a: assert property (
      ins == INS_EXTEST |=> pad_out == $past(upd_out[NP-1:N_IN]))
      else $error("Extest pads do not follow the update stages.");

endmodule

// [tb/bstp_tester.sv]
`timescale 1ns/1ps
// Tester model that drives the serial test port from its own link clock.
module bstp_tester
(
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   // The link clock stands low between frames; TMS and TDI start high.
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // One link cycle: set TMS and TDI while low, sample TDO before the rise.
   task automatic tick(input logic ms, input logic di, output logic dout);
      tms = ms;
      tdi = di;
      #60.0;
      dout = tdo;
      #1.25 tck = 1'b1; // The rise stays clear of core clock edges.
      #63.75 tck = 1'b0;
   endtask

   // Five cycles with TMS high reach the reset state, then park in idle.
   task automatic go_reset();
      logic d;
      repeat (5) tick(1'b1, 1'b1, d);
      tick(1'b0, 1'b1, d);
   endtask

   // From idle, shift n bits LSB first into IR or DR, update, back to idle.
   task automatic scan(input bit ir, input logic [63:0] din, input int n,
                       output logic [63:0] dout);
      logic d;
      dout = '0;
      tick(1'b1, 1'b1, d);
      if (ir)
         tick(1'b1, 1'b1, d);
      tick(1'b0, 1'b1, d);
      tick(1'b0, 1'b1, d);
      for (int i = 0; i < n; i++)
         tick(i == n - 1, din[i], dout[i]);
      tick(1'b1, 1'b1, d);
      tick(1'b0, 1'b1, d);
   endtask
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import bstp_pkg::*;
   localparam int NI  = 4;
   localparam int NO  = 4;
   localparam int NM  = 2;
   localparam int NCH = 3 * (NI + NO + NM);
   // Identification value is arbitrary; bit zero stays one.
   localparam logic [31:0] IDV = 32'h1234_5679;

   logic           core_clk = 1'b0;
   logic           rstn;
   logic           test_port_en;
   wire logic [3:0] tp_pin_in;
   logic [3:0]     tp_pin_out;
   logic [3:0]     tp_pin_oe;
   logic [3:0]     tp_out;
   logic [3:0]     tp_oe;
   logic [3:0]     tp_gpio_in;
   logic           tms_pull_en;
   logic           tdi_pull_en;
   logic [7:0]     pad_in;
   logic [3:0]     core_out;
   logic [3:0]     core_oe;
   logic [3:0]     pad_out;
   logic [3:0]     pad_oe;
   logic [7:0]     core_in;
   logic [1:0]     mc_fb;
   logic [1:0]     mc_out;
   logic [1:0]     mc_oe;
   logic [1:0]     mc_fb_core;
   logic           tck;
   logic           tms;
   logic           tdi;
   wire logic      tdo_w;
   logic           tdo_last = 1'b0;
   logic [3:0]     gpio_pat;
   int             num_errors = 0;
   int             n_checks = 0;

   // The clock toggles every half period of 2.5 ns.
   always #2.5 core_clk = ~core_clk;

   // A released TDO line shows the inverse of its last driven value.
   always @(posedge core_clk)
      if (tp_pin_oe[3])
         tdo_last <= tp_pin_out[3];
   assign tdo_w = tp_pin_oe[3] ? tp_pin_out[3] : ~tdo_last;
   // Test pins carry the link when enabled and a plain pattern otherwise.
   assign tp_pin_in = test_port_en ? {tdo_w, tdi, tms, tck} : gpio_pat;

   bstp_top #(.N_IN(NI), .N_IO(NO), .N_MC(NM), .ID_VALUE(IDV)) u_bstp_top
   (
      .core_clk     (core_clk),
      .rstn         (rstn),
      .test_port_en (test_port_en),
      .tp_pin_in    (tp_pin_in),
      .tp_pin_out   (tp_pin_out),
      .tp_pin_oe    (tp_pin_oe),
      .tp_out       (tp_out),
      .tp_oe        (tp_oe),
      .tp_gpio_in   (tp_gpio_in),
      .tms_pull_en  (tms_pull_en),
      .tdi_pull_en  (tdi_pull_en),
      .pad_in       (pad_in),
      .core_out     (core_out),
      .core_oe      (core_oe),
      .pad_out      (pad_out),
      .pad_oe       (pad_oe),
      .core_in      (core_in),
      .mc_fb        (mc_fb),
      .mc_out       (mc_out),
      .mc_oe        (mc_oe),
      .mc_fb_core   (mc_fb_core)
   );

   bstp_tester u_bstp_tester
   (
      .tck (tck),
      .tms (tms),
      .tdi (tdi),
      .tdo (tdo_w)
   );

   // Compares one value and counts the outcome.
   task automatic chk(input string name, input logic [63:0] exp,
                      input logic [63:0] got);
      n_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Prints the counts and the verdict, then ends the run.
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // With the port disabled the test pins act as plain I/O without pulls.
   task automatic t_gpio();
      @(negedge core_clk);
      test_port_en = 1'b0;
      tp_out = 4'hA;
      tp_oe = 4'h5;
      gpio_pat = 4'h3;
      repeat (8) @(negedge core_clk);
      chk("tp_pin_out", 64'hA, 64'(tp_pin_out));
      chk("tp_pin_oe", 64'h5, 64'(tp_pin_oe));
      chk("tp_gpio_in", 64'h3, 64'(tp_gpio_in));
      chk("pulls_off", 64'h0, 64'({tms_pull_en, tdi_pull_en}));
      test_port_en = 1'b1;
      repeat (8) @(negedge core_clk);
      chk("pulls_on", 64'h3, 64'({tms_pull_en, tdi_pull_en}));
      chk("tp_gpio_en", 64'h0, 64'(tp_gpio_in));
      chk("tp_oe_en", 64'h0, 64'(tp_pin_oe[2:0]));
      chk("tp_out_en", 64'h0, 64'(tp_pin_out[2:0]));
   endtask

   // After the reset state the identification register is selected.
   task automatic t_idcode();
      logic [63:0] d;
      u_bstp_tester.go_reset();
      u_bstp_tester.scan(1'b0, 64'h0, 32, d);
      chk("idcode", 64'(IDV), d);
      chk("pad_out_norm", 64'(core_out), 64'(pad_out));
      chk("pad_oe_norm", 64'(core_oe), 64'(pad_oe));
   endtask

   // Bypass and an undefined opcode give a one-bit path.
   task automatic t_bypass();
      logic [63:0]       d;
      logic [IR_LEN-1:0] ops [2];
      ops[0] = OP_BYPASS;
      ops[1] = 4'h7;
      for (int k = 0; k < 2; k++)
      begin
         u_bstp_tester.scan(1'b1, 64'(ops[k]), IR_LEN, d);
         chk("ir_capture", 64'(IR_CAPT), d);
         u_bstp_tester.scan(1'b0, 64'hA5, 8, d);
         chk("bypass", 64'h4A, d);
      end
   endtask

   // Sample captures the pins, preloads the cells, extest drives them.
   task automatic t_sample_extest();
      logic [63:0] d;
      logic [63:0] e;
      logic [63:0] p;
      logic [3:0]  eo;
      logic [3:0]  eoe;
      logic [7:0]  eci;
      logic [1:0]  emc;
      @(negedge core_clk);
      pad_in = 8'h5A;
      core_out = 4'h9;
      core_oe = 4'h6;
      mc_fb = 2'h2;
      mc_out = 2'h1;
      mc_oe = 2'h3;
      u_bstp_tester.scan(1'b1, 64'(OP_SAMPLE), IR_LEN, d);
      chk("pad_out_samp", 64'h9, 64'(pad_out));
      chk("core_in", 64'h5A, 64'(core_in));
      chk("mc_fb_core", 64'h2, 64'(mc_fb_core));
      p = 64'h2B6D_9E35 & ((64'h1 << NCH) - 64'h1);
      u_bstp_tester.scan(1'b0, p, NCH, d);
      e = '0;
      for (int i = 0; i < NI + NO; i++)
      begin
         e[3 * i] = pad_in[i];
         if (i >= NI)
         begin
            e[3 * i + 1] = core_out[i - NI];
            e[3 * i + 2] = core_oe[i - NI];
         end
      end
      // Macrocell cells sit nearest TDI and observe feedback, output, enable.
      for (int k = 0; k < NM; k++)
      begin
         e[3 * (NI + NO + k)] = mc_fb[k];
         e[3 * (NI + NO + k) + 1] = mc_out[k];
         e[3 * (NI + NO + k) + 2] = mc_oe[k];
      end
      chk("sample_chain", e, d);
      for (int j = 0; j < NO; j++)
      begin
         eo[j] = p[3 * (NI + j) + 1];
         eoe[j] = p[3 * (NI + j) + 2];
      end
      for (int j = 0; j < NI + NO; j++)
         eci[j] = p[3 * j + 1];
      for (int k = 0; k < NM; k++)
         emc[k] = p[3 * (NI + NO + k) + 1];
      u_bstp_tester.scan(1'b1, 64'(OP_EXTEST), IR_LEN, d);
      chk("extest_out", 64'(eo), 64'(pad_out));
      chk("extest_oe", 64'(eoe), 64'(pad_oe));
      chk("extest_core_in", 64'(eci), 64'(core_in));
      chk("extest_mc_fb", 64'(emc), 64'(mc_fb_core));
   endtask

   // Highz floats all pads and routes data through the bypass bit.
   task automatic t_highz();
      logic [63:0] d;
      u_bstp_tester.scan(1'b1, 64'(OP_HIGHZ), IR_LEN, d);
      chk("highz_oe", 64'h0, 64'(pad_oe));
      u_bstp_tester.scan(1'b0, 64'hB, 4, d);
      chk("highz_bypass", 64'h6, d);
   endtask

   // A reset in mid-run restores the reset state and the identification.
   task automatic t_reset();
      logic [63:0] d;
      logic        b;
      @(negedge core_clk);
      rstn = 1'b0;
      repeat (2) @(negedge core_clk);
      rstn = 1'b1;
      repeat (6) @(negedge core_clk);
      u_bstp_tester.tick(1'b0, 1'b1, b);
      u_bstp_tester.scan(1'b0, 64'h0, 32, d);
      chk("idcode_rst", 64'(IDV), d);
      chk("pad_oe_rst", 64'(core_oe), 64'(pad_oe));
   endtask

   // Inputs start at rest, reset is held for two cycles, then tests run.
   initial
   begin
      rstn = 1'b0;
      test_port_en = 1'b1;
      tp_out = 4'h0;
      tp_oe = 4'h0;
      gpio_pat = 4'h0;
      pad_in = 8'h00;
      core_out = 4'h0;
      core_oe = 4'h0;
      mc_fb = 2'h0;
      mc_out = 2'h0;
      mc_oe = 2'h0;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      rstn = 1'b1;
      repeat (6) @(negedge core_clk);
      t_gpio();
      t_idcode();
      t_bypass();
      t_sample_extest();
      t_highz();
      t_reset();
      t_idcode();
      end_of_test();
   end

   // The tests need about 31 us; a hang is cut short at 100 us.
   initial
   begin
      #100000;
      num_errors++;
      end_of_test();
   end
endmodule
